/* src/lpt_clkgen.sv */
// Source clock sampling, selection and prescaler producing the count tick
`include "lpt_defines.svh"

module lpt_clkgen
    import lpt_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Slow clock pins
    input  wire logic       sub_clk_pin,
    input  wire logic       wdt_clk_pin,
    input  wire logic       low_speed_oscillator_clk_pin,
    // Control
    input  wire logic [1:0] source_sel,
    input  wire logic [2:0] prescale_select,
    input  wire logic       stop,
    // Count clock enable
    output logic            count_tick
);

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [2:0] pins;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] edge_w;
    assign pins = {low_speed_oscillator_clk_pin, wdt_clk_pin, sub_clk_pin};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                    sync3_r[g] <= 1'b0;
                end
                else
                begin
                    sync1_r[g] <= pins[g];
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                end
            end
            // Only valid while aclk runs at least four times the source
            assign edge_w[g] = sync2_r[g] & ~sync3_r[g];
        end
    endgenerate

    // ==========================================================
    // Source select, low-speed oscillator divide and prescaler
    logic [1:0] low_speed_oscillator_cnt_r;
    logic [1:0] low_speed_oscillator_cnt_nxt;
    logic [4:0] psc_cnt_r;
    logic [4:0] psc_cnt_nxt;
    logic       src_tick;
    logic       tick_nxt;
    logic [4:0] psc_mask;
    logic [4:0] seen_r;
    logic [4:0] seen_nxt;
    logic       clean_r;
    logic       clean_nxt;
    logic [2:0] psc_last_r;

    always_comb
    begin
        low_speed_oscillator_cnt_nxt = edge_w[2] ? low_speed_oscillator_cnt_r + 2'h1 : low_speed_oscillator_cnt_r;
        unique case (lpt_src_t'(source_sel))
            LPT_SRC_SUB:    src_tick = edge_w[0];
            LPT_SRC_WDT:    src_tick = edge_w[1];
            LPT_SRC_LOW_SPEED_OSCILLATOR_A,
            LPT_SRC_LOW_SPEED_OSCILLATOR_B: src_tick = edge_w[2] && (low_speed_oscillator_cnt_r == `LPT_LOW_SPEED_OSCILLATOR_DIV);
        endcase
        // Illegal codes fall back to no division
        case (prescale_select)
            LPT_PSC_DIV2:  psc_mask = 5'h01;
            LPT_PSC_DIV4:  psc_mask = 5'h03;
            LPT_PSC_DIV8:  psc_mask = 5'h07;
            LPT_PSC_DIV16: psc_mask = 5'h0f;
            LPT_PSC_DIV32: psc_mask = 5'h1f;
            default:       psc_mask = 5'h00;
        endcase
        psc_cnt_nxt = psc_cnt_r;
        tick_nxt    = 1'b0;
        seen_nxt    = seen_r;
        // A prescale change while running leaves the next ratio undefined
        clean_nxt   = clean_r && (prescale_select == psc_last_r);
        if (stop)
        begin
            psc_cnt_nxt = 5'h00;
            seen_nxt    = 5'h00;
            clean_nxt   = 1'b1;
        end
        else if (src_tick)
        begin
            psc_cnt_nxt = psc_cnt_r + 5'h01;
            tick_nxt    = ((psc_cnt_r & psc_mask) == psc_mask);
            seen_nxt    = tick_nxt ? 5'h00 : seen_r + 5'h01;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_speed_oscillator_cnt_r <= 2'h0;
            psc_cnt_r  <= 5'h00;
            count_tick <= 1'b0;
            seen_r     <= 5'h00;
            clean_r    <= 1'b1;
            psc_last_r <= 3'h0;
        end
        else
        begin
            low_speed_oscillator_cnt_r <= low_speed_oscillator_cnt_nxt;
            psc_cnt_r  <= psc_cnt_nxt;
            count_tick <= tick_nxt;
            seen_r     <= seen_nxt;
            clean_r    <= clean_nxt;
            psc_last_r <= prescale_select;
        end
    end

    // ==========================================================
    // Checks
    // Source edges between two count ticks must equal the divide ratio
    chk_psc_ratio: assert property (@(posedge aclk) disable iff (!aresetn)
        count_tick && $past(clean_r && prescale_select == psc_last_r)
        && $past(prescale_select) <= 3'h5
        |-> $past(seen_r) == 5'((6'h01 << $past(prescale_select)) - 6'h01))
        else $error("count tick after wrong number of source edges");

endmodule // lpt_clkgen

/* src/lpt_defines.svh */
// Register map, field positions, reset values and timing counts of the low-power timer
`ifndef LPT_DEFINES_SVH
`define LPT_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define LPT_OFS_CTRL_ONE    8'h00
`define LPT_OFS_CTRL_TWO    8'h04
`define LPT_OFS_CMP_ONE     8'h08
`define LPT_OFS_CMP_ZERO    8'h0c
`define LPT_OFS_COUNT       8'h10
`define LPT_OFS_IRQ_STAT    8'h14
`define LPT_OFS_IRQ_MASK    8'h18

// ==========================================================
// Field positions
`define LPT_PSC_LSB         0
`define LPT_SRC_LOW_BIT     3
`define LPT_SRC_HIGH_BIT    4
`define LPT_M1_EN_BIT       5
`define LPT_STOP_BIT        0
`define LPT_PWM_EN_BIT      1
`define LPT_POL_BIT         2
`define LPT_LVL_BIT         3
`define LPT_ST_M1_BIT       0
`define LPT_ST_M0_BIT       1

// ==========================================================
// Reset values
`define LPT_CTRL_ONE_RST    8'h00
`define LPT_CTRL_TWO_RST    8'h01
`define LPT_CMP_RST         16'hffff
`define LPT_IRQ_RST         2'h0

// ==========================================================
// Timing counts
`define LPT_LOW_SPEED_OSCILLATOR_DIV        2'h3
`define LPT_BUS_RATIO_MIN   4

`endif

/* src/lpt_pkg.sv */
// Types shared by the low-power timer modules
package lpt_pkg;

    typedef enum logic [2:0] {
        LPT_PSC_DIV1,
        LPT_PSC_DIV2,
        LPT_PSC_DIV4,
        LPT_PSC_DIV8,
        LPT_PSC_DIV16,
        LPT_PSC_DIV32
    } lpt_psc_t;

    typedef enum logic [1:0] {
        LPT_SRC_SUB,
        LPT_SRC_LOW_SPEED_OSCILLATOR_A,
        LPT_SRC_WDT,
        LPT_SRC_LOW_SPEED_OSCILLATOR_B
    } lpt_src_t;

endpackage

/* src/lpt_top.sv */
// Low-power timer: AXI4-Lite registers, 16-bit counter, compare matches and PWM output
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`include "lpt_defines.svh"

module lpt_top
    import lpt_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    aclk,
    aresetn,
    // AXI4-Lite slave
    awvalid, awready, awaddr,
    wvalid, wready, wdata, wstrb,
    bvalid, bready, bresp,
    arvalid, arready, araddr,
    rvalid, rready, rdata, rresp,
    // Slow clock pins and power state
    sub_clk_pin, wdt_clk_pin, low_speed_oscillator_clk_pin, sw_standby,
    // Outputs
    timer_output_pin, match0_event, match1_event, irq
);
    input  wire logic        aclk;
    input  wire logic        aresetn;
    input  wire logic        awvalid;
    output logic             awready;
    input  wire logic [7:0]  awaddr;
    input  wire logic        wvalid;
    output logic             wready;
    input  wire logic [31:0] wdata;
    input  wire logic [3:0]  wstrb;
    output logic             bvalid;
    input  wire logic        bready;
    output logic [1:0]       bresp;
    input  wire logic        arvalid;
    output logic             arready;
    input  wire logic [7:0]  araddr;
    output logic             rvalid;
    input  wire logic        rready;
    output logic [31:0]      rdata;
    output logic [1:0]       rresp;
    input  wire logic        sub_clk_pin;
    input  wire logic        wdt_clk_pin;
    input  wire logic        low_speed_oscillator_clk_pin;
    input  wire logic        sw_standby;
    output logic             timer_output_pin;
    output logic             match0_event;
    output logic             match1_event;
    output logic             irq;

    initial
    begin
        if (CNT_W != 16)
            $error("CNT_W must be 16");
    end

    // ==========================================================
    // Register state
    logic [7:0]       ctrl1_r, ctrl1_nxt;
    logic [7:0]       ctrl2_r, ctrl2_nxt;
    logic [CNT_W-1:0] cmp1_r, cmp1_nxt;
    logic [CNT_W-1:0] cmp0_r, cmp0_nxt;
    logic [1:0]       stat_r, stat_nxt;
    logic [1:0]       mask_r, mask_nxt;
    logic             aw_got_r, aw_got_nxt;
    logic             w_got_r, w_got_nxt;
    logic [7:0]       wa_r, wa_nxt;
    logic [31:0]      wd_r, wd_nxt;
    logic [3:0]       ws_r, ws_nxt;
    logic             awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
    logic [1:0]       bresp_nxt, rresp_nxt;
    logic [31:0]      rdata_nxt;

    logic       count_tick;
    logic       stop;
    logic       m1_en;
    logic [1:0] hw_set;

    assign stop  = ctrl2_r[`LPT_STOP_BIT];
    assign m1_en = ctrl1_r[`LPT_M1_EN_BIT];

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `LPT_OFS_CTRL_ONE) || (a == `LPT_OFS_CTRL_TWO) ||
                    (a == `LPT_OFS_CMP_ONE)  || (a == `LPT_OFS_CMP_ZERO) ||
                    (a == `LPT_OFS_COUNT)    || (a == `LPT_OFS_IRQ_STAT) ||
                    (a == `LPT_OFS_IRQ_MASK);
    endfunction

    // ==========================================================
    // Count clock generation
    lpt_clkgen u_clkgen (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .sub_clk_pin     (sub_clk_pin),
        .wdt_clk_pin     (wdt_clk_pin),
        .low_speed_oscillator_clk_pin    (low_speed_oscillator_clk_pin),
        .source_sel      ({ctrl1_r[`LPT_SRC_HIGH_BIT], ctrl1_r[`LPT_SRC_LOW_BIT]}),
        .prescale_select (ctrl1_r[2:0]),
        .stop            (stop),
        .count_tick      (count_tick)
    );

    // ==========================================================
    // Counter, compare matches and PWM
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic             m0_lvl_r, m0_lvl_nxt;
    logic             m1_lvl_r, m1_lvl_nxt;
    logic             pwm_r, pwm_nxt;
    logic             out_nxt, m0_evt_nxt, m1_evt_nxt;

    always_comb
    begin
        cnt_nxt    = cnt_r;
        m0_lvl_nxt = m0_lvl_r;
        m1_lvl_nxt = m1_lvl_r;
        pwm_nxt    = pwm_r;
        m0_evt_nxt = 1'b0;
        m1_evt_nxt = 1'b0;
        if (stop)
        begin
            cnt_nxt    = '0;
            m0_lvl_nxt = 1'b0;
            m1_lvl_nxt = 1'b0;
            pwm_nxt    = 1'b1;
        end
        // Standby does not gate the tick, so counting carries on
        else if (count_tick)
        begin
            // Compare zero sets the period
            cnt_nxt    = (cnt_r == cmp0_r) ? '0 : cnt_r + 1'b1;
            m0_lvl_nxt = (cnt_nxt == cmp0_r) && sw_standby;
            m1_lvl_nxt = (cnt_nxt == cmp1_r) && m1_en;
            m0_evt_nxt = m0_lvl_nxt;
            m1_evt_nxt = m1_lvl_nxt;
            if (cnt_nxt == cmp1_r)
                pwm_nxt = 1'b0;
            else if (cnt_nxt == '0)
                pwm_nxt = 1'b1;
        end
        if (ctrl2_r[`LPT_PWM_EN_BIT])
            out_nxt = pwm_nxt ^ ctrl2_r[`LPT_POL_BIT];
        else
            out_nxt = ctrl2_r[`LPT_LVL_BIT];
        hw_set = {m0_evt_nxt, m1_evt_nxt};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r            <= '0;
            m0_lvl_r         <= 1'b0;
            m1_lvl_r         <= 1'b0;
            pwm_r            <= 1'b1;
            timer_output_pin <= 1'b0;
            match0_event     <= 1'b0;
            match1_event     <= 1'b0;
        end
        else
        begin
            cnt_r            <= cnt_nxt;
            m0_lvl_r         <= m0_lvl_nxt;
            m1_lvl_r         <= m1_lvl_nxt;
            pwm_r            <= pwm_nxt;
            timer_output_pin <= out_nxt;
            match0_event     <= m0_evt_nxt;
            match1_event     <= m1_evt_nxt;
        end
    end

    // ==========================================================
    // AXI4-Lite slave and registers
    always_comb
    begin
        ctrl1_nxt   = ctrl1_r;
        ctrl2_nxt   = ctrl2_r;
        cmp1_nxt    = cmp1_r;
        cmp0_nxt    = cmp0_r;
        mask_nxt    = mask_r;
        stat_nxt    = stat_r;
        aw_got_nxt  = aw_got_r || (awvalid && awready);
        w_got_nxt   = w_got_r || (wvalid && wready);
        wa_nxt      = (awvalid && awready) ? awaddr : wa_r;
        wd_nxt      = (wvalid && wready) ? wdata : wd_r;
        ws_nxt      = (wvalid && wready) ? wstrb : ws_r;
        bvalid_nxt  = bvalid && !bready;
        bresp_nxt   = bresp;
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt  = !w_got_nxt && !bvalid_nxt;
        if (aw_got_r && w_got_r && !bvalid)
        begin
            aw_got_nxt  = 1'b0;
            w_got_nxt   = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = is_mapped(wa_r) ? 2'h0 : 2'h2;
            awready_nxt = 1'b0;
            wready_nxt  = 1'b0;
            // Source bits are expected to change only while stopped
            if (wa_r == `LPT_OFS_CTRL_ONE && ws_r[0])
                ctrl1_nxt = wd_r[7:0];
            if (wa_r == `LPT_OFS_CTRL_TWO && ws_r[0])
                ctrl2_nxt = wd_r[7:0];
            if (wa_r == `LPT_OFS_CMP_ONE)
            begin
                if (ws_r[0]) cmp1_nxt[7:0]  = wd_r[7:0];
                if (ws_r[1]) cmp1_nxt[15:8] = wd_r[15:8];
            end
            if (wa_r == `LPT_OFS_CMP_ZERO)
            begin
                if (ws_r[0]) cmp0_nxt[7:0]  = wd_r[7:0];
                if (ws_r[1]) cmp0_nxt[15:8] = wd_r[15:8];
            end
            if (wa_r == `LPT_OFS_IRQ_MASK && ws_r[0])
                mask_nxt = wd_r[1:0];
            if (wa_r == `LPT_OFS_IRQ_STAT && ws_r[0])
                stat_nxt = stat_r & ~wd_r[1:0];
        end
        // A new event wins over a same-cycle clear
        stat_nxt = stat_nxt | hw_set;

        rvalid_nxt  = rvalid && !rready;
        rdata_nxt   = rdata;
        rresp_nxt   = rresp;
        arready_nxt = !rvalid_nxt;
        if (arvalid && arready)
        begin
            rvalid_nxt  = 1'b1;
            arready_nxt = 1'b0;
            rresp_nxt   = is_mapped(araddr) ? 2'h0 : 2'h2;
            case (araddr)
                `LPT_OFS_CTRL_ONE: rdata_nxt = {24'h0, ctrl1_r};
                `LPT_OFS_CTRL_TWO: rdata_nxt = {24'h0, ctrl2_r};
                `LPT_OFS_CMP_ONE:  rdata_nxt = {16'h0, cmp1_r};
                `LPT_OFS_CMP_ZERO: rdata_nxt = {16'h0, cmp0_r};
                `LPT_OFS_COUNT:    rdata_nxt = {16'h0, cnt_r};
                `LPT_OFS_IRQ_STAT: rdata_nxt = {30'h0, stat_r};
                `LPT_OFS_IRQ_MASK: rdata_nxt = {30'h0, mask_r};
                default:           rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl1_r  <= `LPT_CTRL_ONE_RST;
            ctrl2_r  <= `LPT_CTRL_TWO_RST;
            cmp1_r   <= `LPT_CMP_RST;
            cmp0_r   <= `LPT_CMP_RST;
            stat_r   <= `LPT_IRQ_RST;
            mask_r   <= `LPT_IRQ_RST;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            wa_r     <= 8'h00;
            wd_r     <= 32'h0;
            ws_r     <= 4'h0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            arready  <= 1'b0;
            rvalid   <= 1'b0;
            rdata    <= 32'h0;
            rresp    <= 2'h0;
            irq      <= 1'b0;
        end
        else
        begin
            ctrl1_r  <= ctrl1_nxt;
            ctrl2_r  <= ctrl2_nxt;
            cmp1_r   <= cmp1_nxt;
            cmp0_r   <= cmp0_nxt;
            stat_r   <= stat_nxt;
            mask_r   <= mask_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            wa_r     <= wa_nxt;
            wd_r     <= wd_nxt;
            ws_r     <= ws_nxt;
            awready  <= awready_nxt;
            wready   <= wready_nxt;
            bvalid   <= bvalid_nxt;
            bresp    <= bresp_nxt;
            arready  <= arready_nxt;
            rvalid   <= rvalid_nxt;
            rdata    <= rdata_nxt;
            rresp    <= rresp_nxt;
            irq      <= |(stat_nxt & mask_nxt);
        end
    end

    // ==========================================================
    // Checks
    chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
        count_tick && !stop && cnt_r != cmp0_r |=> cnt_r == $past(cnt_r) + 16'h1)
        else $error("counter did not step on tick");
    chk_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !count_tick && !stop |=> $stable(cnt_r))
        else $error("counter moved without a tick");
    chk_m0_standby: assert property (@(posedge aclk) disable iff (!aresetn)
        match0_event |-> $past(sw_standby))
        else $error("match zero event outside standby");
    chk_m1_event: assert property (@(posedge aclk) disable iff (!aresetn)
        match1_event |-> cnt_r == cmp1_r && $past(m1_en))
        else $error("match one event without equality");
    chk_m1_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        match1_event && mask_r[0] |-> irq)
        else $error("interrupt missing on match one");
    chk_pwm_out: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ctrl2_r[1]) && $past(ctrl2_r) == ctrl2_r
        |-> timer_output_pin == (pwm_r ^ ctrl2_r[2]))
        else $error("pwm output wrong");
    chk_level_out: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl2_r[1] ##1 !ctrl2_r[1] && $stable(ctrl2_r) |-> timer_output_pin == ctrl2_r[3])
        else $error("output level wrong");
    chk_m1_release: assert property (@(posedge aclk) disable iff (!aresetn)
        m1_lvl_r && count_tick && !stop ##1 cnt_r != cmp1_r |-> !m1_lvl_r)
        else $error("match one not released");

endmodule // lpt_top

/* test/low_power_timer_tb.sv */
// Self-checking bench of the low-power timer: registers, counting, matches, output pin
`include "lpt_defines.svh"

module low_power_timer_tb
    import lpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ====================
    // Signals
    localparam int         LIMIT = 40000;
    localparam logic [7:0] C1    = `LPT_OFS_CTRL_ONE;
    localparam logic [7:0] C2    = `LPT_OFS_CTRL_TWO;
    localparam logic [7:0] K1    = `LPT_OFS_CMP_ONE;
    localparam logic [7:0] K0    = `LPT_OFS_CMP_ZERO;
    localparam logic [7:0] CNT   = `LPT_OFS_COUNT;
    localparam logic [7:0] ST    = `LPT_OFS_IRQ_STAT;
    localparam logic [7:0] MK    = `LPT_OFS_IRQ_MASK;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        sw_standby, pin, m0, m1, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, lf;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [2:0]  src;
    logic [33:0] e;
    logic [33:0] rq[$];
    logic [1:0]  wq[$];
    int          n_fail, cmp_count, cyc, m0n, m1n;
    logic [7:0]  ra [8] = '{C1, C2, K1, K0, CNT, ST, MK, 8'h1c};
    logic [15:0] rv [8] = '{16'h0, 16'h1, 16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h0};

    // ====================
    // Design
    lpt_top #(.CNT_W(16)) i_lpt_top (
        .aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .sub_clk_pin(src[0]), .wdt_clk_pin(src[1]), .low_speed_oscillator_clk_pin(src[2]),
        .sw_standby(sw_standby), .timer_output_pin(pin),
        .match0_event(m0), .match1_event(m1), .irq(irq)
    );

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // ====================
    // Tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
            n_fail++;
        end
    endtask

    // Address and data are offered together; each is released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit ta;
        bit tw;
        ta = 1'b0;
        tw = 1'b0;
        wq.push_back(r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (!ta && awready)
                awvalid <= 1'b0;
            ta |= awready;
            if (!tw && wready)
                wvalid <= 1'b0;
            tw |= wready;
        end
        while (!(ta && tw));
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask

    // Source pin high and low 4 cycles each, well inside the 4x ratio
    task automatic edges(input int p, input int n);
        repeat (n)
        begin
            src[p] <= 1'b1;
            repeat (4) @(posedge aclk);
            src[p] <= 1'b0;
            repeat (4) @(posedge aclk);
        end
        repeat (12) @(posedge aclk);
    endtask

    // Stop first: source bits may only change while the clock is stopped
    task automatic cfg(input logic [7:0] c1v, input logic [7:0] c2v);
        wr(C2, 32'h1, 2'h0);
        wr(C1, {24'h0, c1v}, 2'h0);
        wr(C2, {24'h0, c2v}, 2'h0);
    endtask

    // ====================
    // Monitors
    always @(posedge aclk)
    begin
        cyc++;
        if (m0)
            m0n++;
        if (m1)
            m1n++;
        if (rvalid && rready)
        begin
            e = rq.pop_front();
            check("rdata", rdata, e[31:0]);
            check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
        end
        if (bvalid && bready)
            check("bresp", {30'h0, bresp}, {30'h0, wq.pop_front()});
        if (cyc == LIMIT)
        begin
            n_fail++;
            close_out();
        end
    end

    // ====================
    // Main sequence
    initial
    begin
        aresetn    = 1'b0;
        awvalid    = 1'b0;
        wvalid     = 1'b0;
        bready     = 1'b0;
        arvalid    = 1'b0;
        rready     = 1'b0;
        awaddr     = 8'h0;
        araddr     = 8'h0;
        wdata      = 32'h0;
        wstrb      = 4'h0;
        src        = 3'h0;
        sw_standby = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 8; i++)
            rd(ra[i], {16'h0, rv[i]}, (i == 7) ? 2'h2 : 2'h0);
        wr(8'h1c, 32'h5, 2'h2);
        lf = lfsr(32'h40b2);
        wr(K1, lf, 2'h0);
        rd(K1, {16'h0, lf[15:0]}, 2'h0);
        lf = lfsr(lf);
        wr(K0, lf, 2'h0);
        rd(K0, {16'h0, lf[15:0]}, 2'h0);
        wr(C1, 32'h25, 2'h0);
        rd(C1, 32'h25, 2'h0);
        wr(C2, 32'hd, 2'h0);
        rd(C2, 32'hd, 2'h0);
        wr(K0, 32'h7, 2'h0);
        wr(K1, 32'h3, 2'h0);
        wr(MK, 32'h3, 2'h0);
        m0n = 0;
        for (int p = 0; p < 6; p++)
        begin
            m1n = 0;
            cfg(8'h20 | 8'(p), 8'h0);
            edges(0, 3 << p);
            rd(CNT, 32'h3, 2'h0);
            edges(0, 5 << p);
            rd(CNT, 32'h0, 2'h0);
            check("match1 count", m1n, 1);
            check("irq", 32'(irq), 32'h1);
            rd(ST, 32'h1, 2'h0);
            wr(ST, 32'h1, 2'h0);
            repeat (2) @(posedge aclk);
            check("irq", 32'(irq), 32'h0);
        end
        check("match0 count", m0n, 0);
        for (int s = 0; s < 4; s++)
        begin
            m1n = 0;
            cfg(8'(s << 3), 8'h0);
            edges((s == 0) ? 0 : (s == 2) ? 1 : 2, (s % 2 == 1) ? 12 : 3);
            rd(CNT, 32'h3, 2'h0);
            check("match1 count", m1n, 0);
        end
        sw_standby <= 1'b1;
        cfg(8'h0, 8'h0);
        edges(0, 8);
        rd(CNT, 32'h0, 2'h0);
        check("match0 count", m0n, 1);
        check("irq", 32'(irq), 32'h1);
        rd(ST, 32'h2, 2'h0);
        wr(ST, 32'h2, 2'h0);
        sw_standby <= 1'b0;
        wr(MK, 32'h0, 2'h0);
        cfg(8'h20, 8'h0);
        edges(0, 8);
        check("irq", 32'(irq), 32'h0);
        rd(ST, 32'h1, 2'h0);
        wr(ST, 32'h1, 2'h0);
        for (int o = 0; o < 2; o++)
        begin
            cfg(8'h0, 8'h02 | 8'(o << 2));
            edges(0, 1);
            check("pin", 32'(pin), 32'(o == 0));
            edges(0, 4);
            check("pin", 32'(pin), 32'(o == 1));
        end
        wr(C2, 32'h9, 2'h0);
        repeat (3) @(posedge aclk);
        check("pin", 32'(pin), 32'h1);
        wr(C2, 32'h1, 2'h0);
        repeat (3) @(posedge aclk);
        check("pin", 32'(pin), 32'h0);
        close_out();
    end

endmodule // low_power_timer_tb
